// File: core/pbl_pkg.sv
// pbl_pkg: constants, widths and state codes for the pushbutton/led state controller
// assumes a single 25 MHz core clock; every timer runs off a 1 ms tick derived from it
package pbl_pkg;

  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned TICK_MS    = 1;
  // cycles per timebase tick, derived from the clock rate
  localparam int unsigned TICK_CYC   = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned TICK_W     = 15;

  localparam int unsigned DEB_MS     = 10;
  localparam int unsigned DEB_W      = 4;
  localparam int unsigned BLINK_MS   = 100;
  localparam int unsigned FLASH_MS   = 200;
  localparam int unsigned HOLD_S     = 12;
  localparam int unsigned HOLD_MS    = HOLD_S * 1000;
  localparam int unsigned PAUSE_MIN  = 15;
  localparam int unsigned PAUSE_MS   = PAUSE_MIN * 60 * 1000;
  localparam int unsigned MS_W       = 20;

  localparam logic [DEB_W-1:0]  DEB_LIM   = DEB_W'(DEB_MS);
  localparam logic [MS_W-1:0]   BLINK_LIM = MS_W'(BLINK_MS - 1);
  localparam logic [MS_W-1:0]   FLASH_LIM = MS_W'(FLASH_MS);
  localparam logic [TICK_W-1:0] TICK_RST  = 15'h0000;
  localparam logic [MS_W-1:0]   MS_RST    = 20'h00000;

  typedef enum logic [3:0] {
    PBL_OFF    = 4'h1,
    PBL_SEARCH = 4'h2,
    PBL_READY  = 4'h4,
    PBL_PAUSED = 4'h8
  } pbl_state_t;

endpackage : pbl_pkg

// File: core/pbl_debounce.sv
// pbl_debounce: two-flop synchroniser and stable-time filter for the pushbutton pin
// assumes ms_tick_i is a one-cycle pulse per millisecond on core_clk_i
`timescale 1ns/1ps
module pbl_debounce
  import pbl_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic ms_tick_i,
  input  wire logic raw_i,
  output logic      level_o
);

  logic             sync_a;
  logic             sync_b;
  logic [DEB_W-1:0] stable_cnt;
  logic [DEB_W-1:0] next_stable_cnt;
  logic             next_level;

  always_comb
  begin
    next_stable_cnt = stable_cnt;
    next_level      = level_o;
    if (sync_b == level_o)
    begin
      next_stable_cnt = '0;
    end
    else if (ms_tick_i)
    begin
      // a level must differ for the whole window before it is taken
      if (stable_cnt == DEB_LIM - 4'h1)
      begin
        next_level      = sync_b;
        next_stable_cnt = '0;
      end
      else
      begin
        next_stable_cnt = stable_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      sync_a     <= 1'b0;
      sync_b     <= 1'b0;
      stable_cnt <= '0;
      level_o    <= 1'b0;
    end
    else
    begin
      sync_a     <= raw_i;
      sync_b     <= sync_a;
      stable_cnt <= next_stable_cnt;
      level_o    <= next_level;
    end
  end

endmodule : pbl_debounce

// File: core/pbl_ctrl.sv
// pbl_ctrl: operating-state controller driven by one pushbutton with a status led
// assumes link_up_i and the sweep strobes come from logic on core_clk_i; button_i is a raw pin
`timescale 1ns/1ps
module pbl_ctrl
  import pbl_pkg::*;
#(
  parameter int unsigned TICK_CYC_P = TICK_CYC,
  parameter int unsigned HOLD_MS_P  = HOLD_MS,
  parameter int unsigned PAUSE_MS_P = PAUSE_MS
)
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic button_i,
  input  wire logic link_up_i,
  input  wire logic sweep_start_i,
  input  wire logic sweep_end_i,
  output logic      led_o,
  output logic      power_en_o,
  output logic      measure_en_o,
  output logic      voc_capture_o,
  output logic      source_stop_o,
  output logic      unit_reset_o
);

  localparam logic [TICK_W-1:0] TICK_LIM = TICK_W'(TICK_CYC_P - 1);
  localparam logic [MS_W-1:0]   HOLD_LIM  = MS_W'(HOLD_MS_P);
  localparam logic [MS_W-1:0]   PAUSE_LIM = MS_W'(PAUSE_MS_P);

  pbl_state_t        state;
  pbl_state_t        next_state;
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic              ms_tick;
  logic              btn_level;
  logic              btn_prev;
  logic [MS_W-1:0]   hold_cnt;
  logic [MS_W-1:0]   next_hold_cnt;
  logic [MS_W-1:0]   pause_cnt;
  logic [MS_W-1:0]   next_pause_cnt;
  logic [MS_W-1:0]   blink_cnt;
  logic [MS_W-1:0]   next_blink_cnt;
  logic              blink_phase;
  logic              next_blink_phase;
  logic [MS_W-1:0]   flash_cnt;
  logic [MS_W-1:0]   next_flash_cnt;
  logic              next_led;
  logic              next_voc;
  logic              next_stop;
  logic              next_reset;
  logic              release_evt;
  logic              long_hold;
  logic              short_press;
  logic              long_release;
  logic              sweep_go;

  // timebase: one pulse per millisecond keeps the long timers narrow
  always_comb
  begin
    next_tick_cnt = tick_cnt + 15'h0001;
    ms_tick       = 1'b0;
    if (tick_cnt == TICK_LIM)
    begin
      next_tick_cnt = TICK_RST;
      ms_tick       = 1'b1;
    end
  end

  pbl_debounce u_debounce (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ms_tick_i  (ms_tick),
    .raw_i      (button_i),
    .level_o    (btn_level)
  );

  always_comb
  begin
    release_evt   = btn_prev & ~btn_level;
    long_hold     = (hold_cnt >= HOLD_LIM);
    short_press   = release_evt & ~long_hold;
    long_release  = release_evt & long_hold;
    next_hold_cnt = MS_RST;
    if (btn_level)
    begin
      next_hold_cnt = hold_cnt;
      if (ms_tick && !long_hold)
      begin
        next_hold_cnt = hold_cnt + 20'h00001;
      end
    end
  end

  // operating state sequence; a reset hold outranks every other event
  always_comb
  begin
    next_state = state;
    case (state)
      PBL_OFF:
      begin
        if (short_press || long_release)
        begin
          next_state = PBL_SEARCH;
        end
      end
      PBL_SEARCH:
      begin
        // link only appears once the host side is ready
        if (!long_release && link_up_i)
        begin
          next_state = PBL_READY;
        end
      end
      PBL_READY:
      begin
        // lost link goes back to search
        if (long_release || !link_up_i)
        begin
          next_state = PBL_SEARCH;
        end
        else if (short_press)
        begin
          next_state = PBL_PAUSED;
        end
      end
      PBL_PAUSED:
      begin
        if (long_release)
        begin
          next_state = PBL_SEARCH;
        end
        else if (short_press)
        begin
          next_state = link_up_i ? PBL_READY : PBL_SEARCH;
        end
        else if (!btn_level && ms_tick && (pause_cnt >= PAUSE_LIM))
        begin
          next_state = PBL_OFF;
        end
      end
      default:
      begin
        next_state = PBL_OFF;
      end
    endcase
  end

  // pause timer, cleared on leaving pause
  always_comb
  begin
    next_pause_cnt = MS_RST;
    if (state == PBL_PAUSED)
    begin
      next_pause_cnt = pause_cnt;
      if (ms_tick && (pause_cnt < PAUSE_LIM))
      begin
        next_pause_cnt = pause_cnt + 20'h00001;
      end
    end
  end

  always_comb
  begin
    next_blink_cnt   = MS_RST;
    next_blink_phase = 1'b1;
    if (state == PBL_SEARCH)
    begin
      next_blink_cnt   = blink_cnt;
      next_blink_phase = blink_phase;
      if (ms_tick)
      begin
        if (blink_cnt == BLINK_LIM)
        begin
          next_blink_cnt   = MS_RST;
          next_blink_phase = ~blink_phase;
        end
        else
        begin
          next_blink_cnt = blink_cnt + 20'h00001;
        end
      end
    end
  end

  // sweeps start only when enabled; a pending button event takes the cycle first
  always_comb
  begin
    sweep_go       = sweep_start_i && (state == PBL_READY) && !release_evt;
    next_flash_cnt = flash_cnt;
    if (sweep_go)
    begin
      next_flash_cnt = FLASH_LIM;
    end
    else if (state != PBL_READY)
    begin
      next_flash_cnt = MS_RST;
    end
    else if (ms_tick && (flash_cnt != MS_RST))
    begin
      next_flash_cnt = flash_cnt - 20'h00001;
    end
  end

  // led and strobe outputs, each one held in a register below
  always_comb
  begin
    next_led = 1'b0;
    case (state)
      PBL_SEARCH: next_led = blink_phase;
      PBL_READY:  next_led = (flash_cnt == MS_RST);
      PBL_PAUSED: next_led = 1'b0;
      default:    next_led = 1'b0;
    endcase
    next_voc   = sweep_go;
    next_stop  = sweep_end_i && (state != PBL_OFF);
    next_reset = long_release;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state         <= PBL_OFF;
      tick_cnt      <= TICK_RST;
      btn_prev      <= 1'b0;
      hold_cnt      <= MS_RST;
      pause_cnt     <= MS_RST;
      blink_cnt     <= MS_RST;
      blink_phase   <= 1'b1;
      flash_cnt     <= MS_RST;
      led_o         <= 1'b0;
      voc_capture_o <= 1'b0;
      source_stop_o <= 1'b0;
      unit_reset_o  <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      tick_cnt      <= next_tick_cnt;
      btn_prev      <= btn_level;
      hold_cnt      <= next_hold_cnt;
      pause_cnt     <= next_pause_cnt;
      blink_cnt     <= next_blink_cnt;
      blink_phase   <= next_blink_phase;
      flash_cnt     <= next_flash_cnt;
      led_o         <= next_led;
      voc_capture_o <= next_voc;
      source_stop_o <= next_stop;
      unit_reset_o  <= next_reset;
    end
  end

  assign power_en_o   = (state != PBL_OFF);
  assign measure_en_o = (state == PBL_READY);

  property p_power_on;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_OFF && short_press) |=> (state == PBL_SEARCH) && power_en_o;
  endproperty
  a_power_on: assert property (p_power_on) else $error("press while off did not start search");

  property p_search_blink;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_SEARCH && ms_tick && blink_cnt == BLINK_LIM && next_state == PBL_SEARCH)
        |=> ##1 (led_o != $past(led_o));
  endproperty
  a_search_blink: assert property (p_search_blink) else $error("search led did not toggle");

  property p_ready_steady;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_READY && flash_cnt == MS_RST)[*2] |-> led_o;
  endproperty
  a_ready_steady: assert property (p_ready_steady) else $error("enabled led not on");

  property p_pause_blocks;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_READY && link_up_i && short_press && !long_release)
        |=> !measure_en_o ##1 !voc_capture_o;
  endproperty
  a_pause_blocks: assert property (p_pause_blocks) else $error("pause did not block sweeps");

  property p_pause_dark;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_PAUSED)[*2] |-> !led_o && !voc_capture_o;
  endproperty
  a_pause_dark: assert property (p_pause_dark) else $error("led lit while paused");

  property p_auto_off;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_PAUSED && pause_cnt >= PAUSE_LIM && ms_tick && !btn_level && !release_evt)
        |=> (state == PBL_OFF) && !power_en_o;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("idle pause did not power off");

  property p_resume;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_PAUSED && short_press && link_up_i) |=> measure_en_o;
  endproperty
  a_resume: assert property (p_resume) else $error("press while paused did not resume");

  property p_flash;
    @(posedge core_clk_i) disable iff (reset_i)
      (sweep_go && link_up_i) |=> voc_capture_o && (flash_cnt == FLASH_LIM) ##1 !led_o;
  endproperty
  a_flash: assert property (p_flash) else $error("sweep start gave no flash");

  property p_link_lost;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == PBL_READY && !link_up_i) |=> (state == PBL_SEARCH) && !measure_en_o;
  endproperty
  a_link_lost: assert property (p_link_lost) else $error("lost link not back to search");

  property p_long_reset;
    @(posedge core_clk_i) disable iff (reset_i)
      (release_evt && hold_cnt >= HOLD_LIM)
        |=> unit_reset_o && (state == PBL_SEARCH) ##1 !unit_reset_o;
  endproperty
  a_long_reset: assert property (p_long_reset) else $error("long hold did not reset");

  property p_long_not_short;
    @(posedge core_clk_i) disable iff (reset_i)
      (release_evt && long_hold && state == PBL_READY) |=> state != PBL_PAUSED;
  endproperty
  a_long_not_short: assert property (p_long_not_short) else $error("long hold paused unit");

  property p_voc_only_enabled;
    @(posedge core_clk_i) disable iff (reset_i)
      voc_capture_o |-> $past(state == PBL_READY) && $past(sweep_start_i);
  endproperty
  a_voc_only_enabled: assert property (p_voc_only_enabled) else $error("voc without sweep");

  property p_source_stop;
    @(posedge core_clk_i) disable iff (reset_i)
      (sweep_end_i && power_en_o) |=> source_stop_o;
  endproperty
  a_source_stop: assert property (p_source_stop) else $error("source not stopped at end");

endmodule : pbl_ctrl

// File: dv/pbl_host_model.sv
// pbl_host_model: operator at the pushbutton plus the wireless host link side
// assumes the bench calls its tasks; every pin moves 1 ns after a rising clock edge
`timescale 1ns/1ps
module pbl_host_model
#(
  parameter int unsigned TICK_CYC_P = 4
)
(
  input  wire logic core_clk_i,
  output logic      button_o,
  output logic      link_up_o,
  output logic      sweep_start_o,
  output logic      sweep_end_o
);
  initial
  begin
    button_o      = 1'b0;
    link_up_o     = 1'b0;
    sweep_start_o = 1'b0;
    sweep_end_o   = 1'b0;
  end

  // the make edge bounces once, so the filter always sees chatter first
  task automatic press(input int ms);
    begin
      @(posedge core_clk_i);
      #1 button_o = 1'b1;
      @(posedge core_clk_i);
      #1 button_o = 1'b0;
      @(posedge core_clk_i);
      #1 button_o = 1'b1;
      repeat (ms * TICK_CYC_P) @(posedge core_clk_i);
      #1 button_o = 1'b0;
    end
  endtask : press

  task automatic set_link(input logic up);
    begin
      @(posedge core_clk_i);
      #1 link_up_o = up;
    end
  endtask : set_link

  task automatic pulse(input bit is_end);
    begin
      @(posedge core_clk_i);
      #1 sweep_start_o = !is_end;
      sweep_end_o = is_end;
      @(posedge core_clk_i);
      #1 sweep_start_o = 1'b0;
      sweep_end_o = 1'b0;
    end
  endtask : pulse
endmodule : pbl_host_model

// File: dv/pbl_ctrl_test.sv
// pbl_ctrl_test: self-checking bench for the pushbutton/led controller
// assumes shortened timers: 4 cycles per ms tick, 20 ms hold, 50 ms pause limit
// the pause limit leaves room for a resume press before the idle power-off
`timescale 1ns/1ps
module pbl_ctrl_test;
  import pbl_pkg::*;
  localparam int unsigned TCK = 4;
  localparam int          LIMIT = 20000;

  logic core_clk_i;
  logic reset_i;
  logic button;
  logic link_up;
  logic sweep_start;
  logic sweep_end;
  logic led_o;
  logic power_en_o;
  logic measure_en_o;
  logic voc_capture_o;
  logic source_stop_o;
  logic unit_reset_o;
  int   n_errors;
  int   cmp_count;
  int   cyc;

  pbl_ctrl #(.TICK_CYC_P(TCK), .HOLD_MS_P(20), .PAUSE_MS_P(50)) dut
  (
    .core_clk_i    (core_clk_i),
    .reset_i       (reset_i),
    .button_i      (button),
    .link_up_i     (link_up),
    .sweep_start_i (sweep_start),
    .sweep_end_i   (sweep_end),
    .led_o         (led_o),
    .power_en_o    (power_en_o),
    .measure_en_o  (measure_en_o),
    .voc_capture_o (voc_capture_o),
    .source_stop_o (source_stop_o),
    .unit_reset_o  (unit_reset_o)
  );

  pbl_host_model #(.TICK_CYC_P(TCK)) host
  (
    .core_clk_i    (core_clk_i),
    .button_o      (button),
    .link_up_o     (link_up),
    .sweep_start_o (sweep_start),
    .sweep_end_o   (sweep_end)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  function automatic logic sig(input int sel);
    case (sel)
      0: return led_o;
      1: return power_en_o;
      2: return measure_en_o;
      3: return voc_capture_o;
      4: return source_stop_o;
      default: return unit_reset_o;
    endcase
  endfunction : sig

  task automatic check(input string name, input logic exp, input logic got);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        n_errors++;
        $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
    end
  endtask : check

  // samples on falling edges, away from the design's update edge
  task automatic wait_val(input string name, input int sel, input logic v, input int maxc);
    logic hit;
    begin
      hit = 1'b0;
      repeat (maxc)
      begin
        @(negedge core_clk_i);
        if (sig(sel) === v)
          hit = 1'b1;
        if (hit)
          break;
      end
      check(name, 1'b1, hit);
    end
  endtask : wait_val

  task automatic toggles(input string name, input int sel, input int n, input bit many);
    int   cnt;
    logic last;
    begin
      cnt = 0;
      @(negedge core_clk_i);
      last = sig(sel);
      repeat (n)
      begin
        @(negedge core_clk_i);
        if (sig(sel) !== last)
          cnt++;
        last = sig(sel);
      end
      check(name, many, cnt >= 2);
      if (!many)
        check(name, 1'b0, cnt != 0);
    end
  endtask : toggles

  task automatic final_report();
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask : final_report

  task automatic t_power_on();
    begin
      host.press(12);
      wait_val("power_on", 1, 1'b1, 100);
      check("measure_off_search", 1'b0, measure_en_o);
      toggles("search_blink", 0, 1000, 1'b1);
      $display("t_power_on done");
    end
  endtask : t_power_on

  task automatic t_link_up();
    begin
      host.set_link(1'b1);
      wait_val("ready_measure", 2, 1'b1, 3);
      wait_val("ready_led", 0, 1'b1, 4);
      toggles("ready_steady", 0, 500, 1'b0);
      $display("t_link_up done");
    end
  endtask : t_link_up

  task automatic t_sweep();
    begin
      host.pulse(1'b0);
      wait_val("voc_strobe", 3, 1'b1, 2);
      wait_val("flash_dark", 0, 1'b0, 4);
      wait_val("flash_back", 0, 1'b1, 900);
      host.pulse(1'b1);
      wait_val("source_stop", 4, 1'b1, 2);
      $display("t_sweep done");
    end
  endtask : t_sweep

  task automatic t_bounce();
    begin
      host.press(2);
      toggles("glitch_ignored", 2, 150, 1'b0);
      $display("t_bounce done");
    end
  endtask : t_bounce

  task automatic t_pause();
    begin
      host.press(12);
      wait_val("pause_entry", 2, 1'b0, 100);
      wait_val("pause_dark", 0, 1'b0, 3);
      // a start while paused must not reach the capture strobe
      host.pulse(1'b0);
      repeat (3)
      begin
        @(negedge core_clk_i);
        check("paused_no_voc", 1'b0, voc_capture_o);
      end
      toggles("pause_led_steady", 0, 100, 1'b0);
      host.press(12);
      wait_val("resume", 2, 1'b1, 100);
      check("resume_power", 1'b1, power_en_o);
      wait_val("resume_led", 0, 1'b1, 3);
      $display("t_pause done");
    end
  endtask : t_pause

  task automatic t_link_loss();
    begin
      host.set_link(1'b0);
      wait_val("loss_search", 2, 1'b0, 3);
      check("loss_power", 1'b1, power_en_o);
      toggles("loss_blink", 0, 1000, 1'b1);
      host.set_link(1'b1);
      wait_val("relink", 2, 1'b1, 3);
      $display("t_link_loss done");
    end
  endtask : t_link_loss

  task automatic t_long_hold();
    begin
      host.press(40);
      wait_val("unit_reset", 5, 1'b1, 100);
      // with the link still up and no press, only a search state can return to ready
      wait_val("no_pause_on_hold", 2, 1'b1, 4);
      $display("t_long_hold done");
    end
  endtask : t_long_hold

  task automatic t_timeout();
    begin
      host.press(12);
      wait_val("pause_again", 2, 1'b0, 100);
      // 40 ms ticks of 4 cycles: still on well before the 50 ms limit
      repeat (160) @(negedge core_clk_i);
      check("early_power", 1'b1, power_en_o);
      wait_val("auto_off", 1, 1'b0, 100);
      host.press(12);
      wait_val("power_again", 1, 1'b1, 100);
      $display("t_timeout done");
    end
  endtask : t_timeout

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_errors++;
      final_report();
    end
  end

  initial
  begin
    n_errors  = 0;
    cmp_count = 0;
    cyc       = 0;
    reset_i   = 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1 reset_i = 1'b0;
    @(negedge core_clk_i);
    check("reset_power", 1'b0, power_en_o);
    check("reset_led", 1'b0, led_o);
    t_power_on();
    t_link_up();
    t_sweep();
    t_bounce();
    t_pause();
    t_link_loss();
    t_long_hold();
    t_timeout();
    final_report();
  end
endmodule : pbl_ctrl_test
